// ---- rtl/ioevs_counting.sv ----
// event selection and per-counter increment logic for the io unit counters
`timescale 1ns/10ps
module ioevs_counting
  import ioevs_pkg::*;
(
  input  wire  logic                                  clk_sys,
  input  wire  logic                                  rst_n,
  input  wire  ioevs_ctrl_type [NUM_COUNTERS-1:0]     ctrl,
  input  wire  ioevs_debug_type [NUM_BUSES-1:0]       debug_in,
  input  wire  ioevs_pipe_type                        pipe,
  output logic [NUM_COUNTERS-1:0][INC_WIDTH-1:0]      increment,
  output logic [NUM_COUNTERS-1:0][CNT_WIDTH-1:0]      count
);

  ////////////////////////////////////////////////////////////////////////////////
  // debug bus mask/match

  logic [NUM_BUSES-1:0] and_hit;
  logic [NUM_BUSES-1:0] or_hit;

  genvar b;
  generate
    for (b = 0; b < NUM_BUSES; b++) begin : g_bus
      ioevs_mask_match u_mm (
        .dbg     (debug_in[b]),
        .and_hit (and_hit[b]),
        .or_hit  (or_hit[b])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // combination select, any selected term counts once
  function automatic logic bus_combo(input logic [1:0] hit, input logic [7:0] um);
    logic [5:0] terms;
    terms[UM_NON_PCIE_DEBUG_BUS]            = hit[0];
    terms[UM_PCIE_DEBUG_BUS]            = hit[1];
    terms[UM_NON_PCIE_DEBUG_BUS_NOT_PCIE_DEBUG_BUS]   = hit[0] & ~hit[1];
    terms[UM_NON_PCIE_DEBUG_BUS_PCIE_DEBUG_BUS]       = hit[0] & hit[1];
    terms[UM_NOT_NON_PCIE_DEBUG_BUS_PCIE_DEBUG_BUS]   = ~hit[0] & hit[1];
    terms[UM_NOT_NON_PCIE_DEBUG_BUS_NOT_B1] = ~hit[0] & ~hit[1];
    return |(terms & um[5:0]);
  endfunction : bus_combo

  ////////////////////////////////////////////////////////////////////////////////
  // per-counter event selection

  logic [NUM_COUNTERS-1:0][INC_WIDTH-1:0] next_increment;
  logic [NUM_COUNTERS-1:0][CNT_WIDTH-1:0] next_count;

  genvar c;
  generate
    for (c = 0; c < NUM_COUNTERS; c++) begin : g_cnt
      logic [SUM_WIDTH-1:0]   out_occ;
      logic [SUM_WIDTH-1:0]   in_occ;
      logic [INC_WIDTH-1:0]   raw_inc;
      logic [NUM_COUNTERS-1:0] allowed;
      logic [7:0]             um;
      // gated increment and next count of this counter
      logic [INC_WIDTH-1:0]   gated_inc;
      logic [CNT_WIDTH-1:0]   summed_count;

      assign um = ctrl[c].umask;

      ////////////////////////////////////////////////////////////////////////////
      // outbound queue sum over the selected flow class and channel
      always_comb begin
        out_occ = '0;
        for (int f = 0; f < NUM_FC; f++) begin
          for (int h = 0; h < NUM_CH; h++) begin
            if (ctrl[c].flow_class_select[f] && ctrl[c].channel_select[h]) begin
              out_occ = out_occ + SUM_WIDTH'(pipe.outbound_queue_occupancy[f*NUM_CH+h]);
            end
          end
        end
        if (out_occ > MAX_OUTBOUND_OCC) begin
          out_occ = MAX_OUTBOUND_OCC;
        end
      end

      ////////////////////////////////////////////////////////////////////////////
      // inbound stage sum, posted-only stages take the posted count
      always_comb begin
        in_occ = '0;
        for (int s = 0; s < NUM_STAGES; s++) begin
          if (um[s]) begin
            if (POSTED_ONLY_STAGES[s]) begin
              in_occ = in_occ + SUM_WIDTH'(pipe.stage_posted[s]);
            end else begin
              in_occ = in_occ + SUM_WIDTH'(pipe.stage_total[s]);
            end
          end
        end
        if (in_occ > MAX_INBOUND_OCC) begin
          in_occ = MAX_INBOUND_OCC;
        end
      end

      ////////////////////////////////////////////////////////////////////////////
      // counters on which the selected event may run
      always_comb begin
        unique case (ctrl[c].event_code)
          EV_MASK_MATCH_AND,
          EV_MASK_MATCH_OR: begin
            allowed = CNT_MASK_MATCH;
          end
          EV_OUTBOUND_QUEUE_OCC: begin
            allowed = CNT_OCCUPANCY;
          end
          EV_INBOUND_OUTST_OCC: begin
            allowed = CNT_OCCUPANCY;
          end
          default: begin
            allowed = CNT_ANY;
          end
        endcase
      end

      ////////////////////////////////////////////////////////////////////////////
      // event decode into the raw increment
      always_comb begin
        raw_inc = '0;
        unique case (ctrl[c].event_code)
          EV_MASK_MATCH_AND: begin
            raw_inc = INC_WIDTH'(bus_combo(and_hit, um));
          end
          EV_MASK_MATCH_OR: begin
            raw_inc = INC_WIDTH'(bus_combo(or_hit, um));
          end
          EV_OUTBOUND_QUEUE_OCC: begin
            raw_inc = um[UM_TOWARD_DEVICE] ? INC_WIDTH'(out_occ) : '0;
          end
          EV_INBOUND_OUTST_OCC: begin
            raw_inc = INC_WIDTH'(in_occ);
          end
          EV_OUTBOUND_REQS: begin
            raw_inc = INC_WIDTH'((um[UM_FROM_REQ_PATH] & pipe.io_request_path)
                               | (um[UM_FROM_TXN_CTRL] & pipe.inbound_transaction_control)
                               | (um[UM_FROM_CMPL_ALLOC] & pipe.completion_allocations));
          end
          EV_INBOUND_FULL_REQS: begin
            raw_inc = INC_WIDTH'((um[UM_COMMIT_ALL] & pipe.full_request)
                               | (um[UM_DROP] & pipe.drop_request));
          end
          EV_INBOUND_PER_TARGET: begin
            raw_inc = INC_WIDTH'(|(um & pipe.target_hit));
          end
          EV_OUTBOUND_LINE: begin
            raw_inc = INC_WIDTH'(um[UM_TOWARD_DEVICE] & pipe.line_done
                               & pipe.line_toward_device);
          end
          EV_OUTBOUND_PACKET: begin
            raw_inc = INC_WIDTH'(um[UM_TOWARD_DEVICE] & pipe.packet_done
                               & pipe.packet_toward_device);
          end
          EV_PAGE_WALK_OCC: begin
            raw_inc = pipe.page_walk_occupancy;
          end
          EV_NOTHING: begin
            raw_inc = '0;
          end
          default: begin
            raw_inc = '0;
          end
        endcase
      end

      ////////////////////////////////////////////////////////////////////////////
      // enable gate and restriction to the allowed counters
      always_comb begin
        gated_inc = '0;
        if (ctrl[c].enable && allowed[c]) begin
          gated_inc = raw_inc;
        end
      end

      ////////////////////////////////////////////////////////////////////////////
      // accumulation, clear wins over the add of the same cycle
      always_comb begin
        summed_count = count[c] + CNT_WIDTH'(increment[c]);
        if (ctrl[c].clear) begin
          summed_count = '0;
        end
      end

      // hand the next values to the shared registers
      assign next_increment[c] = gated_inc;
      assign next_count[c]     = summed_count;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      increment <= '0;
      count     <= '0;
    end else begin
      increment <= next_increment;
      count     <= next_count;
    end
  end

endmodule : ioevs_counting

// ---- rtl/ioevs_pkg.sv ----
// package: constants and carriers for the io unit event select and counting block
package ioevs_pkg;

  localparam int NUM_COUNTERS = 4;
  localparam int NUM_BUSES    = 2;
  localparam int DBG_WIDTH    = 32;
  localparam int INC_WIDTH    = 10;
  localparam int CNT_WIDTH    = 48;
  localparam int SUM_WIDTH    = 13;
  localparam int OCC_WIDTH    = 9;
  localparam int NUM_FC       = 3;
  localparam int NUM_CH       = 4;
  localparam int NUM_QUEUES   = NUM_FC * NUM_CH;
  localparam int NUM_STAGES   = 6;
  localparam int NUM_TARGETS  = 8;

  // event codes
  localparam logic [7:0] EV_MASK_MATCH_AND     = 8'h02;
  localparam logic [7:0] EV_MASK_MATCH_OR      = 8'h03;
  localparam logic [7:0] EV_PAGE_WALK_OCC      = 8'h42;
  localparam logic [7:0] EV_NOTHING            = 8'h80;
  localparam logic [7:0] EV_INBOUND_FULL_REQS  = 8'h85;
  localparam logic [7:0] EV_INBOUND_OUTST_OCC  = 8'h88;
  localparam logic [7:0] EV_INBOUND_PER_TARGET = 8'h8E;
  localparam logic [7:0] EV_OUTBOUND_REQS      = 8'hC2;
  localparam logic [7:0] EV_OUTBOUND_QUEUE_OCC = 8'hC5;
  localparam logic [7:0] EV_OUTBOUND_LINE      = 8'hD0;
  localparam logic [7:0] EV_OUTBOUND_PACKET    = 8'hD1;

  // sub-event bit positions
  localparam int UM_NON_PCIE_DEBUG_BUS            = 0;
  localparam int UM_PCIE_DEBUG_BUS            = 1;
  localparam int UM_NON_PCIE_DEBUG_BUS_NOT_PCIE_DEBUG_BUS   = 2;
  localparam int UM_NON_PCIE_DEBUG_BUS_PCIE_DEBUG_BUS       = 3;
  localparam int UM_NOT_NON_PCIE_DEBUG_BUS_PCIE_DEBUG_BUS   = 4;
  localparam int UM_NOT_NON_PCIE_DEBUG_BUS_NOT_B1 = 5;
  localparam int UM_FROM_REQ_PATH   = 0;
  localparam int UM_FROM_TXN_CTRL   = 1;
  localparam int UM_FROM_CMPL_ALLOC = 2;
  localparam int UM_COMMIT_ALL      = 0;
  localparam int UM_DROP            = 1;
  localparam int UM_TOWARD_DEVICE   = 3;

  // stages that count posted requests only: ownership, line write, data
  localparam logic [NUM_STAGES-1:0] POSTED_ONLY_STAGES = 6'h34;

  // counters on which each group of events may run
  localparam logic [NUM_COUNTERS-1:0] CNT_MASK_MATCH = 4'h3;
  localparam logic [NUM_COUNTERS-1:0] CNT_OCCUPANCY  = 4'hC;
  localparam logic [NUM_COUNTERS-1:0] CNT_ANY        = 4'hF;

  // largest outbound and inbound occupancy increment per cycle
  localparam logic [SUM_WIDTH-1:0] MAX_OUTBOUND_OCC = 13'h0100;
  localparam logic [SUM_WIDTH-1:0] MAX_INBOUND_OCC  = 13'h0200;

  typedef struct packed {
    logic                    enable;
    logic                    clear;
    logic [7:0]              event_code;
    logic [7:0]              umask;
    logic [NUM_FC-1:0]       flow_class_select;
    logic [NUM_CH-1:0]       channel_select;
  } ioevs_ctrl_type;

  typedef struct packed {
    logic [DBG_WIDTH-1:0]    bus;
    logic [DBG_WIDTH-1:0]    mask;
    logic [DBG_WIDTH-1:0]    match;
  } ioevs_debug_type;

  typedef struct packed {
    logic [NUM_QUEUES-1:0][OCC_WIDTH-1:0]  outbound_queue_occupancy;
    logic [NUM_STAGES-1:0][INC_WIDTH-1:0]  stage_total;
    logic [NUM_STAGES-1:0][INC_WIDTH-1:0]  stage_posted;
    logic                                  io_request_path;
    logic                                  inbound_transaction_control;
    logic                                  completion_allocations;
    logic                                  full_request;
    logic                                  drop_request;
    logic [NUM_TARGETS-1:0]                target_hit;
    logic                                  line_done;
    logic                                  line_toward_device;
    logic                                  packet_done;
    logic                                  packet_toward_device;
    logic [INC_WIDTH-1:0]                  page_walk_occupancy;
  } ioevs_pipe_type;

endpackage : ioevs_pkg

// ---- rtl/ioevs_mask_match.sv ----
// mask/match comparison of one debug bus
`timescale 1ns/10ps
module ioevs_mask_match
  import ioevs_pkg::*;
(
  input  wire ioevs_debug_type dbg,
  output logic                and_hit,
  output logic                or_hit
);

  logic [DBG_WIDTH-1:0] equal_bits;

  assign equal_bits = ~(dbg.bus ^ dbg.match);
  assign and_hit    = &(equal_bits | ~dbg.mask);
  assign or_hit     = |(equal_bits & dbg.mask);

endmodule : ioevs_mask_match

// ---- sim/ioevs_properties.sv ----
// checker for the io unit event counting block
`timescale 1ns/10ps
module ioevs_properties
  import ioevs_pkg::*;
(
  input wire logic                                   clk_sys,
  input wire logic                                   rst_n,
  input wire ioevs_ctrl_type [NUM_COUNTERS-1:0]      ctrl,
  input wire ioevs_debug_type [NUM_BUSES-1:0]        debug_in,
  input wire ioevs_pipe_type                         pipe,
  input wire logic [NUM_COUNTERS-1:0][INC_WIDTH-1:0] increment,
  input wire logic [NUM_COUNTERS-1:0][CNT_WIDTH-1:0] count
);
  wire and0 = ((debug_in[0].bus ^ debug_in[0].match) & debug_in[0].mask) == '0;
  wire or0  = |(~(debug_in[0].bus ^ debug_in[0].match) & debug_in[0].mask);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  sequence s_walk_sel; ctrl[1].enable && ctrl[1].event_code == 8'h42; endsequence
  sequence s_walk_add; s_walk_sel ##1 !ctrl[1].clear; endsequence
  property p_and_hit; ctrl[0].enable && ctrl[0].event_code == 8'h02 && ctrl[0].umask == 8'h01
    |=> increment[0] == {9'h000, $past(and0)}; endproperty
  a_and_hit: assert property (p_and_hit) else $error("and hit");
  property p_or_hit; ctrl[1].enable && ctrl[1].event_code == 8'h03 && ctrl[1].umask == 8'h01
    |=> increment[1] == {9'h000, $past(or0)}; endproperty
  a_or_hit: assert property (p_or_hit) else $error("or hit");
  property p_mm_limit; ctrl[2].event_code inside {8'h02, 8'h03} |=> increment[2] == 10'h000;
  endproperty
  a_mm_limit: assert property (p_mm_limit) else $error("mask match counter");
  property p_outq_clamp; ctrl[2].event_code == 8'hC5 |=> increment[2] <= 10'h100; endproperty
  a_outq_clamp: assert property (p_outq_clamp) else $error("outbound clamp");
  property p_outq_limit; ctrl[0].event_code == 8'hC5 |=> increment[0] == 10'h000; endproperty
  a_outq_limit: assert property (p_outq_limit) else $error("outbound counter");
  property p_inq_clamp; ctrl[3].event_code == 8'h88 |=> increment[3] <= 10'h200; endproperty
  a_inq_clamp: assert property (p_inq_clamp) else $error("inbound clamp");
  property p_pulse_one; ctrl[0].event_code inside {8'h85, 8'h8E, 8'hC2, 8'hD0, 8'hD1}
    |=> increment[0] <= 10'h001; endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("pulse above one");
  property p_line_wait; ctrl[0].event_code == 8'hD0 && !pipe.line_done
    |=> increment[0] == 10'h000; endproperty
  a_line_wait: assert property (p_line_wait) else $error("line early");
  property p_walk_inc; s_walk_sel |=> increment[1] == $past(pipe.page_walk_occupancy);
  endproperty
  a_walk_inc: assert property (p_walk_inc) else $error("walk increment");
  property p_walk_count; s_walk_add |=> count[1] == $past(count[1])
    + CNT_WIDTH'($past(pipe.page_walk_occupancy, 2)); endproperty
  a_walk_count: assert property (p_walk_count) else $error("walk count");
endmodule : ioevs_properties

// ---- sim/ioevs_pipe_model.sv ----
// far-side model: pipeline event sources and debug buses
`timescale 1ns/10ps
module ioevs_pipe_model
  import ioevs_pkg::*;
(
  output ioevs_debug_type [NUM_BUSES-1:0] debug_in,
  output ioevs_pipe_type                  pipe
);
  initial begin
    debug_in = '0;
    pipe = '0;
  end
  // k: 0 no masked bit matches, 1 some masked bits match, 2 all masked bits match
  task automatic set_bus(input int b, input int k);
    debug_in[b] = (k == 2) ? {32'hA5, 32'hF0, 32'hA0} :
                  {(k == 1) ? 32'h00 : 32'hFF, 32'hFF, (k == 1) ? 32'h0F : 32'h00};
  endtask : set_bus
  task automatic fire(input logic [15:0] v);
    pipe.io_request_path = v[0];
    pipe.inbound_transaction_control = v[1];
    pipe.completion_allocations = v[2];
    pipe.full_request = v[3];
    pipe.drop_request = v[4];
    pipe.line_done = v[5] | v[7];
    pipe.line_toward_device = v[5];
    pipe.packet_done = v[6];
    pipe.packet_toward_device = v[6];
    pipe.target_hit = v[15:8];
  endtask : fire
  task automatic set_occ(input logic [8:0] q, input logic [9:0] t, input logic [9:0] p);
    pipe.outbound_queue_occupancy = {{(NUM_QUEUES-1){9'h001}}, q};
    pipe.stage_total = {NUM_STAGES{t}};
    pipe.stage_posted = {NUM_STAGES{p}};
    pipe.page_walk_occupancy = 10'h3FF;
  endtask : set_occ
endmodule : ioevs_pipe_model

// ---- sim/tb.sv ----
// self-checking bench for the io unit event counting block
`timescale 1ns/10ps
module tb;
  import ioevs_pkg::*;
  logic                                   clk_sys;
  logic                                   rst_n;
  ioevs_ctrl_type [NUM_COUNTERS-1:0]      ctrl;
  ioevs_debug_type [NUM_BUSES-1:0]        debug_in;
  ioevs_pipe_type                         pipe;
  logic [NUM_COUNTERS-1:0][INC_WIDTH-1:0] increment;
  logic [NUM_COUNTERS-1:0][CNT_WIDTH-1:0] count;
  int                                     mismatches;
  int                                     total_checks;
  ioevs_counting ioevs_counting_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl),
    .debug_in(debug_in), .pipe(pipe), .increment(increment), .count(count));
  ioevs_pipe_model ioevs_pipe_model_inst (.debug_in(debug_in), .pipe(pipe));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  function automatic logic [5:0] terms(input logic a, input logic b);
    return {!a & !b, !a & b, a & b, a & !b, b, a};
  endfunction : terms
  task automatic sel(input int c, input logic [7:0] code, input logic [7:0] um);
    ctrl[c] = '{1'b1, 1'b0, code, um, 3'h1, 4'h1};
  endtask : sel
  ////////////////////////////////////////////////////////////
  task automatic t_mask_match;
    for (int k0 = 0; k0 < 3; k0++) begin
      for (int k1 = 0; k1 < 3; k1++) begin
        ioevs_pipe_model_inst.set_bus(0, k0);
        ioevs_pipe_model_inst.set_bus(1, k1);
        for (int i = 0; i < 6; i++) begin
          sel(0, 8'h02, 8'h01 << i);
          sel(1, 8'h03, 8'h01 << i);
          sel(2, 8'h02, 8'h01 << i);
          @(negedge clk_sys);
          check("and", increment[0], terms(k0 == 2, k1 == 2) >> i & 6'h01);
          check("or", increment[1], terms(k0 > 0, k1 > 0) >> i & 6'h01);
          check("and ctr2", increment[2], 48'h0);
        end
      end
    end
  endtask : t_mask_match
  task automatic t_occupancy;
    ioevs_pipe_model_inst.set_occ(9'h12C, 10'h064, 10'h007);
    sel(0, 8'hC5, 8'h08);
    sel(2, 8'hC5, 8'h08);
    for (int i = 0; i < 7; i++) begin
      sel(3, 8'h88, (i == 6) ? 8'h3F : 8'h01 << i);
      @(negedge clk_sys);
      check("outq", increment[2], 48'h100);
      check("outq ctr0", increment[0], 48'h0);
      check("inq", increment[3], (i == 6) ? 48'h141 : (6'h34 >> i & 1) ? 48'h7 : 48'h64);
    end
    ioevs_pipe_model_inst.set_occ(9'h005, 10'h12C, 10'h012);
    @(negedge clk_sys);
    check("outq sel", increment[2], 48'h5);
    check("inq clamp", increment[3], 48'h200);
  endtask : t_occupancy
  task automatic t_pulses;
    logic [7:0]  cd [14] = '{8'hC2, 8'hC2, 8'hC2, 8'hC2, 8'hC2, 8'h85, 8'h85, 8'h85,
                             8'h8E, 8'h8E, 8'hD0, 8'hD0, 8'hD0, 8'hD1};
    logic [7:0]  um [14] = '{8'h01, 8'h02, 8'h04, 8'h03, 8'h07, 8'h01, 8'h02, 8'h03,
                             8'h80, 8'h7F, 8'h08, 8'h08, 8'h08, 8'h08};
    logic [15:0] pv [14] = '{16'h0001, 16'h0002, 16'h0004, 16'h0004, 16'h0007, 16'h0008,
      16'h0010, 16'h0018, 16'h8000, 16'h8000, 16'h0020, 16'h0080, 16'h0000, 16'h0040};
    logic [13:0] ex = 14'h25F7;
    for (int i = 0; i < 14; i++) begin
      sel(0, cd[i], um[i]);
      ioevs_pipe_model_inst.fire(pv[i]);
      @(negedge clk_sys);
      check("pulse", increment[0], ex[i]);
    end
    ioevs_pipe_model_inst.fire(16'h0000);
  endtask : t_pulses
  task automatic t_walk;
    ctrl[1] = '{1'b1, 1'b1, 8'h42, 8'h00, 3'h1, 4'h1};
    @(negedge clk_sys);
    ctrl[1].clear = 1'b0;
    repeat (3) begin
      @(negedge clk_sys);
      check("walk inc", increment[1], 48'h3FF);
    end
    ctrl[1].enable = 1'b0;
    repeat (2) begin
      @(negedge clk_sys);
      check("walk count", count[1], 48'hFFC);
    end
  endtask : t_walk
  task automatic t_refuse;
    ioevs_pipe_model_inst.fire(16'hFFFF);
    ctrl[0] = '{1'b1, 1'b0, 8'h80, 8'hFF, 3'h1, 4'h1};
    sel(1, 8'h88, 8'h3F);
    ctrl[3] = '{1'b1, 1'b1, 8'h42, 8'h00, 3'h1, 4'h1};
    repeat (2) begin
      @(negedge clk_sys);
      check("nothing", increment[0], 48'h0);
      check("inq ctr1", increment[1], 48'h0);
      check("clear inc", increment[3], 48'h3FF);
      check("clear wins", count[3], 48'h0);
    end
  endtask : t_refuse
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    ctrl = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    t_mask_match();
    t_occupancy();
    t_pulses();
    t_walk();
    t_refuse();
    print_verdict();
  end
endmodule : tb
bind ioevs_counting ioevs_properties ioevs_properties_inst (.clk_sys(clk_sys), .rst_n(rst_n),
  .ctrl(ctrl), .debug_in(debug_in), .pipe(pipe), .increment(increment), .count(count));
